// File: common/spi_pkg.sv
// Package for the memory-side power-up and initialization block.
// Assumes a single 25 MHz clock domain; all pin inputs are synchronous.
package spi_pkg;

  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;

  // Longest time for auto-initialization after a Reset, in nanoseconds.
  localparam int MAX_AUTO_INIT_TIME_NS = 10000;
  // Self-calibration duration, chosen inside the documented minimum.
  localparam int INITIAL_CALIBRATION_TIME_NS = 1000;
  // Longest times round down to whole cycles.
  localparam int AUTO_INIT_CYCLES = MAX_AUTO_INIT_TIME_NS / CLK_PERIOD_NS;
  localparam int CALIB_CYCLES = INITIAL_CALIBRATION_TIME_NS / CLK_PERIOD_NS;
  // Own auto-initialization length; must not exceed AUTO_INIT_CYCLES.
  localparam int AUTO_INIT_RUN_CYCLES = AUTO_INIT_CYCLES / 2;

  // Address geometry.
  localparam int ROW_W = 13;
  localparam int COL_W16 = 9;
  localparam int COL_W32 = 8;
  localparam int BANK_W = 2;

  // Mode register addresses.
  localparam logic [7:0] MR_INFO_ADDR = 8'h00;
  localparam logic [7:0] MR_CALIB_ADDR = 8'h0a;
  localparam logic [7:0] MR_RESET_ADDR = 8'h3f;

  // Field positions inside the device information register.
  localparam int AUTO_INIT_BIT = 0;
  localparam int ZQ_RESULT_LSB = 3;
  // Reset values of those fields.
  localparam logic AUTO_INIT_RST = 1'b1;
  localparam logic [1:0] ZQ_RESULT_RST = 2'h0;
  // Self-test result written when calibration ends (no error seen).
  localparam logic [1:0] ZQ_RESULT_OK = 2'h3;

  // Decoded command from the command/address bus.
  typedef enum logic [2:0] {
    SPI_CMD_NOP,
    SPI_CMD_MRW,
    SPI_CMD_MRR,
    SPI_CMD_ACT,
    SPI_CMD_RDWR
  } spi_cmd_type;

  typedef struct packed {
    spi_cmd_type        cmd;
    logic [7:0]         mr_addr;
    logic [BANK_W-1:0]  bank;
    logic [ROW_W-1:0]   row;
    logic [COL_W16-1:0] col;
  } spi_req_type;

  // Internal core access: row, column with bit 0 forced low, bank.
  typedef struct packed {
    logic               valid;
    logic [BANK_W-1:0]  bank;
    logic [ROW_W-1:0]   row;
    logic [COL_W16:0]   col;
  } spi_access_type;

  typedef enum logic [1:0] {
    SPI_BL4,
    SPI_BL8,
    SPI_BL16
  } spi_burst_type;

endpackage

// File: rtl/spi_init.sv
// Memory-side initialization and access-shaping logic.
// Assumes a decoded command stream from the pin interface, one a cycle,
// and a clock enable that freezes everything while low.
// Refresh, power-down and the contents of the writable mode registers are
// left to the core around this block; only the status fields live here.
//
// Behaviour
// - Column bit zero never arrives on the bus and is forced to zero.
// - Unused row and column bits on the bus are ignored.
// - One 4n-bit core word per cycle, four n-bit beats at the pins.
// - Bursts start at the address and run the programmed length.
// - Outputs are high impedance while memory clock enable is low or no burst is running.
// - Before init completes only register reads and power-down allowed.
// - Auto-initialization completes within 10 us of Reset.
// - On completion the memory is idle with all banks precharged.
// - Reads and writes only 1 us after calibration starts; activates once idle.
// - Reset outside power-up restarts initialization from Reset step.
// - Auto-init status reads zero when complete, one while running.
// - Calibration completion updates the pin self-test result field.
`timescale 1ns/1ps

module spi_init (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                clk_en,
  input  wire logic                cke,
  input  wire logic                wide_bus,
  input  wire spi_pkg::spi_req_type req,
  input  wire logic [1:0]          burst_len,
  output logic                     auto_init_status,
  output logic [1:0]               zq_pin_selftest_result,
  output logic                     init_done,
  output logic                     ready_normal,
  output logic                     banks_precharged,
  output logic                     out_enable,
  output spi_pkg::spi_access_type  access,
  output logic [3:0]               beat_count
);

  // Sequencer states; calibration returns to idle unless a Reset arrives during it.
  typedef enum logic [1:0] {
    SPI_ST_WAIT_RESET,
    SPI_ST_AUTO_INIT,
    SPI_ST_IDLE,
    SPI_ST_CALIB
  } spi_state_type;

  // Registers and their next values.
  spi_state_type state_q, state_d;
  logic [15:0]   cnt_q, cnt_d;
  logic          status_q, status_d;
  logic [1:0]    zq_q, zq_d;
  logic          ready_q, ready_d;
  logic          prech_q, prech_d;
  logic          oe_q;
  spi_pkg::spi_access_type acc_q, acc_d;
  logic [3:0]    beat_q, beat_d;
  logic          done_q;

  // Command decode: Reset and calibration writes are keyed by address.
  wire logic is_mrw = req.cmd == spi_pkg::SPI_CMD_MRW;
  wire logic reset_cmd = is_mrw && req.mr_addr == spi_pkg::MR_RESET_ADDR;
  wire logic calib_cmd = is_mrw && req.mr_addr == spi_pkg::MR_CALIB_ADDR;
  wire logic rdwr_cmd = req.cmd == spi_pkg::SPI_CMD_RDWR;
  wire logic act_cmd = req.cmd == spi_pkg::SPI_CMD_ACT;
  // Acceptance of core commands. Reads and writes wait for calibration to
  // finish, so a controller that skips it never reaches the array.
  wire logic rdwr_ok =
    rdwr_cmd && state_q == SPI_ST_IDLE && ready_q;
  wire logic act_ok  = act_cmd && state_q == SPI_ST_IDLE;
  wire logic ai_end  = state_q == SPI_ST_AUTO_INIT && cnt_q == 16'h0000;

  // Column mask drops the unused top bit on the wide part.
  wire logic [spi_pkg::COL_W16-1:0] col_mask =
    wide_bus ? 9'h0ff : 9'h1ff;
  wire logic [spi_pkg::COL_W16-1:0] col_used = req.col & col_mask;
  wire logic [3:0] burst_beats =
    (burst_len == 2'(spi_pkg::SPI_BL16)) ? 4'hf :
    (burst_len == 2'(spi_pkg::SPI_BL8))  ? 4'h7 : 4'h3;
  wire logic cal_end = state_q == SPI_ST_CALIB && cnt_q == 16'h0000;

  // The idle flag is taken from the next state so that init_done can leave
  // a flip-flop and still change on the same edge as the state register.
  wire logic idle_d = state_d == SPI_ST_IDLE;

  // Initialization sequence; a Reset from any state restarts it. The run
  // counter is shared by auto-initialization and calibration, which never
  // overlap, so one counter is enough.
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    status_d = status_q;
    zq_d     = zq_q;
    ready_d  = ready_q;
    case (state_q)
      SPI_ST_WAIT_RESET: begin
        if (reset_cmd) begin
          state_d = SPI_ST_AUTO_INIT;
        end
      end
      SPI_ST_AUTO_INIT: begin
        if (cnt_q == 16'h0000) begin
          state_d  = SPI_ST_IDLE;
          status_d = 1'b0;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      SPI_ST_IDLE: begin
        if (calib_cmd) begin
          state_d = SPI_ST_CALIB;
          cnt_d   = 16'(spi_pkg::CALIB_CYCLES - 1);
          ready_d = 1'b0;
        end
      end
      default: begin
        if (cal_end) begin
          state_d = SPI_ST_IDLE;
          zq_d    = spi_pkg::ZQ_RESULT_OK;
          ready_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
    endcase
    // The Reset wins over every state so reinitialization is immediate.
    if (reset_cmd) begin
      state_d  = SPI_ST_AUTO_INIT;
      cnt_d    = 16'(spi_pkg::AUTO_INIT_RUN_CYCLES - 1);
      status_d = spi_pkg::AUTO_INIT_RST;
      ready_d  = 1'b0;
    end
  end

  // Bank tracking: everything is precharged once initialization ends.
  // A Reset in the same cycle as an activate wins, so no stale open bank
  // survives reinitialization.
  always_comb begin
    prech_d = prech_q;
    if (reset_cmd || ai_end) begin
      prech_d = 1'b1;
    end else if (act_ok) begin
      prech_d = 1'b0;
    end
  end

  // Burst shaping: column bit zero is implied low, beats counted down.
  // A new access reloads the counter, so the controller must space bursts;
  // nothing here queues a second burst behind the first.
  always_comb begin
    acc_d  = '0;
    beat_d = (beat_q != 4'h0) ? beat_q - 4'h1 : 4'h0;
    if (rdwr_ok) begin
      acc_d.valid = 1'b1;
      acc_d.bank  = req.bank;
      acc_d.row   = req.row;
      acc_d.col   = {col_used, 1'b0};
      beat_d      = burst_beats;
    end
  end

  // Control state; frozen while the clock enable is low.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q  <= SPI_ST_WAIT_RESET;
      cnt_q    <= 16'h0000;
      status_q <= spi_pkg::AUTO_INIT_RST;
      zq_q     <= spi_pkg::ZQ_RESULT_RST;
      ready_q  <= 1'b0;
      prech_q  <= 1'b1;
      done_q   <= 1'b0;
    end else if (clk_en) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      status_q <= status_d;
      zq_q     <= zq_d;
      ready_q  <= ready_d;
      prech_q  <= prech_d;
      done_q   <= idle_d;
    end
  end

  // Data path registers. Outputs float whenever the memory clock
  // enable is low, which covers supply ramp and removal.
  // The enable trails the pin by one cycle, as the pin is seen at the edge.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_q  <= '0;
      beat_q <= 4'h0;
      oe_q   <= 1'b0;
    end else if (clk_en) begin
      acc_q  <= acc_d;
      beat_q <= beat_d;
      oe_q   <= cke && beat_d != 4'h0;
    end
  end

  // Every output is a straight copy of a register, so no decode glitch
  // reaches the pins.
  assign auto_init_status       = status_q;
  assign zq_pin_selftest_result = zq_q;
  assign init_done              = done_q;
  assign ready_normal           = ready_q;
  assign banks_precharged       = prech_q;
  assign out_enable             = oe_q;
  assign access                 = acc_q;
  assign beat_count             = beat_q;

endmodule

// File: sim/spi_init_chk.sv
// Concurrent checks on the ports of the initialization block.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps

module spi_init_chk (
  input wire logic                    clock,
  input wire logic                    rstn,
  input wire logic                    clk_en,
  input wire logic                    cke,
  input wire logic                    wide_bus,
  input wire spi_pkg::spi_req_type    req,
  input wire logic                    auto_init_status,
  input wire logic [1:0]              zq_pin_selftest_result,
  input wire logic                    init_done,
  input wire logic                    ready_normal,
  input wire logic                    banks_precharged,
  input wire logic                    out_enable,
  input wire spi_pkg::spi_access_type access
);
  // A frozen clock enable stops all progress, so it also pauses checking.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn || !clk_en);
  // Decoded requests shared by the checks below.
  wire is_rst  = req.cmd == spi_pkg::SPI_CMD_MRW &&
    req.mr_addr == spi_pkg::MR_RESET_ADDR;
  wire is_rdwr = req.cmd == spi_pkg::SPI_CMD_RDWR;

  AST_COL0: assert property (access.valid |-> !access.col[0])
    else $error("column bit zero set");
  AST_WIDE: assert property (access.valid && $past(wide_bus)
    |-> !access.col[9]) else $error("unused column bit kept");
  AST_BUSY: assert property (is_rst |=> auto_init_status)
    else $error("status not busy after reset");
  AST_DONE: assert property (is_rst |-> ##[1:250] !auto_init_status)
    else $error("auto init too slow");
  AST_IDLE: assert property ($rose(init_done) |-> banks_precharged)
    else $error("idle with open bank");
  AST_BLOCK: assert property (auto_init_status |-> !init_done)
    else $error("idle while init runs");
  AST_HIZ: assert property (!cke |=> !out_enable)
    else $error("outputs driven with cke low");
  AST_ZQ: assert property ($rose(ready_normal) |->
    zq_pin_selftest_result == 2'h3) else $error("zq result missing");
  AST_EARLY: assert property (is_rdwr && !ready_normal
    |=> !access.valid) else $error("access before ready");
  AST_ROW: assert property (is_rdwr && init_done && ready_normal && cke
    |=> access.valid && access.row == $past(req.row))
    else $error("burst start address wrong");
endmodule

bind spi_init spi_init_chk i_chk (.*);

// File: sim/spi_ctrl_model.sv
// Controller model that runs the power-up sequence, then raises done.
// Assumes the 40 ns clock; every wait is rounded up to whole cycles.
`timescale 1ns/1ps

module spi_ctrl_model (
  input  wire logic          clock,
  input  wire logic          rstn,
  output logic               cke,
  output spi_pkg::spi_req_type req,
  output logic               done
);
  localparam int T_CKE = 6;
  localparam int T_RST = T_CKE + 5000;
  localparam int T_MRR = T_RST + 260;
  localparam int T_CAL = T_RST + 276;
  localparam int T_CFG = T_CAL + 26;
  localparam int T_END = T_CFG + 3;
  logic [15:0] cnt_q;
  // Strobes for the few cycles that carry a command.
  wire logic at_rst = cnt_q == 16'(T_RST);
  wire logic at_cal = cnt_q == 16'(T_CAL);
  wire logic at_mrr = cnt_q == 16'(T_MRR);
  wire logic at_cfg = cnt_q >= 16'(T_CFG) && cnt_q < 16'(T_END);
  wire logic [15:0] cfg_reg = cnt_q - 16'(T_CFG) + 16'h0001;

  // One counter paces the whole sequence; it stops once done.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cnt_q <= 16'h0000;
    else if (!done) cnt_q <= cnt_q + 16'h0001;
  end
  // Only no-ops and one register read between the two writes, so no illegal command slips in.
  assign cke = cnt_q >= 16'(T_CKE);
  assign done = cnt_q == 16'(T_END);
  // No refresh is sent: the bench spends far less than one refresh
  // interval in normal operation and the block holds no data.
  assign req.cmd = at_mrr ? spi_pkg::SPI_CMD_MRR :
    (at_rst || at_cal || at_cfg) ? spi_pkg::SPI_CMD_MRW :
    spi_pkg::SPI_CMD_NOP;
  // Configuration writes go to registers one, two and three in turn.
  assign req.mr_addr = at_rst ? spi_pkg::MR_RESET_ADDR :
    at_cal ? spi_pkg::MR_CALIB_ADDR :
    at_cfg ? cfg_reg[7:0] : spi_pkg::MR_INFO_ADDR;
  assign req.bank = 2'h0;
  assign req.row = 13'h0000;
  assign req.col = 9'h000;
endmodule

// File: sim/spi_init_tb.sv
// Testbench: model boots the part, then table-driven bursts and reinit.
// Assumes the model holds done once its sequence has finished.
`timescale 1ns/1ps

module spi_init_tb;
  typedef struct packed {
    logic w; logic [1:0] bl; logic [8:0] c; logic [9:0] ec; logic [3:0] eb;
  } spi_row_type;
  spi_row_type rows [4] = '{'{1'b0, 2'h0, 9'h1ff, 10'h3fe, 4'h3},
    '{1'b1, 2'h1, 9'h1ff, 10'h1fe, 4'h7}, '{1'b0, 2'h2, 9'h001, 10'h002, 4'hf},
    '{1'b1, 2'h0, 9'h155, 10'h0aa, 4'h3}};
  logic clock = 0, rstn = 0, clk_en = 1, wide_bus = 0, t_cke = 1;
  logic m_cke, m_done, st, dn, rdy, pre, oe;
  logic [1:0] burst_len = 0, zq;
  logic [3:0] beats;
  spi_pkg::spi_req_type t_req = '0, m_req, req;
  spi_pkg::spi_access_type acc;
  int fails = 0, tests_run = 0;
  wire cke = m_done ? t_cke : m_cke;
  assign req = m_done ? t_req : m_req;

  spi_ctrl_model i_model (.clock(clock), .rstn(rstn), .cke(m_cke),
    .req(m_req), .done(m_done));
  spi_init i_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .cke(cke),
    .wide_bus(wide_bus), .req(req), .burst_len(burst_len),
    .auto_init_status(st), .zq_pin_selftest_result(zq), .init_done(dn),
    .ready_normal(rdy), .banks_precharged(pre), .out_enable(oe),
    .access(acc), .beat_count(beats));

  // Clock and a watchdog well past the expected five and a half thousand cycles.
  initial forever #20 clock = ~clock;
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    summarize();
  end

  task chk(string n, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // One command for one cycle, then a no-op; results read after settling.
  task cmd(spi_pkg::spi_cmd_type c, logic [7:0] a, logic [8:0] col);
    @(posedge clock);
    t_req <= '{c, a, 2'h1, 13'h1abc, col};
    @(posedge clock);
    t_req <= '0;
    #1;
  endtask

  // Boot, table of bursts, then the awkward cases by hand.
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    #1;
    chk("status", 1, st);
    chk("idle_early", 0, dn);
    for (int i = 0; i < 6000 && m_done !== 1'b1; i++) @(posedge clock);
    #1;
    chk("boot", 1, m_done);
    chk("zq", 3, zq);
    chk("ready", 1, rdy);
    chk("idle", 1, dn);
    foreach (rows[i]) begin
      @(posedge clock);
      wide_bus <= rows[i].w;
      burst_len <= rows[i].bl;
      cmd(spi_pkg::SPI_CMD_RDWR, 8'h00, rows[i].c);
      chk("col", rows[i].ec, acc.col);
      chk("beats", rows[i].eb, beats);
      chk("bank", 1, acc.bank);
      chk("row", 16'h1abc, acc.row);
      chk("oe", 1, oe);
    end
    cmd(spi_pkg::SPI_CMD_ACT, 8'h00, 9'h000);
    chk("open", 0, pre);
    @(posedge clock);
    t_cke <= 0;
    cmd(spi_pkg::SPI_CMD_RDWR, 8'h00, 9'h004);
    chk("oe_off", 0, oe);
    // Clock enable low: the burst counter must hold one below its load.
    @(posedge clock);
    t_cke <= 1;
    clk_en <= 0;
    cmd(spi_pkg::SPI_CMD_RDWR, 8'h00, 9'h004);
    chk("frozen", 0, acc.valid);
    chk("frozen_beats", 2, beats);
    @(posedge clock);
    clk_en <= 1;
    cmd(spi_pkg::SPI_CMD_MRW, spi_pkg::MR_RESET_ADDR, 9'h000);
    chk("reinit", 1, st);
    chk("ready_off", 0, rdy);
    chk("reprech", 1, pre);
    cmd(spi_pkg::SPI_CMD_RDWR, 8'h00, 9'h004);
    chk("refused", 0, acc.valid);
    for (int i = 0; i < 250 && dn !== 1'b1; i++) @(posedge clock);
    #1;
    chk("done", 0, st);
    chk("idle", 1, dn);
    chk("prech", 1, pre);
    // Recalibration: not ready one cycle early, ready at the end point.
    cmd(spi_pkg::SPI_CMD_MRW, spi_pkg::MR_CALIB_ADDR, 9'h000);
    repeat (spi_pkg::CALIB_CYCLES - 1) @(posedge clock);
    #1;
    chk("cal_wait", 0, rdy);
    @(posedge clock);
    #1;
    chk("cal_done", 1, rdy);
    cmd(spi_pkg::SPI_CMD_RDWR, 8'h00, 9'h002);
    chk("valid", 1, acc.valid);
    chk("col2", 16'h0004, acc.col);
    // A second reset in mid-run: status, zq result, ready, enable, idle and precharge flags are checked against their reset values.
    @(posedge clock);
    rstn <= 0;
    @(posedge clock);
    #1;
    chk("rst_status", 1, st);
    chk("rst_zq", 0, zq);
    chk("rst_ready", 0, rdy);
    chk("rst_oe", 0, oe);
    @(posedge clock);
    rstn <= 1;
    repeat (2) @(posedge clock);
    #1;
    chk("rst_idle", 0, dn);
    chk("rst_pre", 1, pre);
    summarize();
  end

  task summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule
